// ===== src/rei_regs.vh
`ifndef REI_REGS_VH
`define REI_REGS_VH

// ==========================================
// register byte offsets (avalon, word aligned)
`define REI_OFS_CTRL     8'h00
`define REI_OFS_ERRMASK  8'h04
`define REI_OFS_INTSTAT  8'h08
`define REI_OFS_INTMASK  8'h0C
`define REI_OFS_RATIO    8'h10
`define REI_OFS_STATE    8'h14

// ==========================================
// control register fields
`define REI_CTRL_REFCLK  0
`define REI_CTRL_HALF    1
`define REI_CTRL_POL     2
`define REI_CTRL_OD      3
`define REI_CTRL_W       4

// ==========================================
// error source positions
`define REI_ERR_VALID    0
`define REI_ERR_PARITY   1
`define REI_ERR_BIPHASE  2
`define REI_ERR_CONF     3
`define REI_ERR_SUBCODE_CRC_ERROR     4
`define REI_ERR_CHANNEL_STATUS_CRC_ERROR     5
`define REI_ERR_UNLOCK   6
`define REI_ERR_W        7

// ==========================================
// interrupt status layout: errors in 6:0, ratio update in 7
`define REI_INT_RATIO    7
`define REI_INT_W        8

// ==========================================
// state register fields
`define REI_ST_RXERR     0
`define REI_ST_INTACT    1
`define REI_ST_HWMODE    2
`define REI_ST_RDSEEN    3

// ==========================================
// reset values
`define REI_RST_CTRL     4'h4
`define REI_RST_ERRMASK  7'h7F
`define REI_RST_INTMASK  8'h00
`define REI_RST_RATIO    8'h00

// ==========================================
// ratio format: 256 reference edges per input frame, 6 fraction bits
`define REI_RATIO_SHIFT  2
`define REI_RATIO_MAX    8'hFF

`endif

// ===== src/rei_rxerr.v
`timescale 1ns/10ps

// ==========================================
// receiver error evaluation, once per sub-frame
module rei_rxerr #(
	parameter NERR = 7
) (
	input  wire            clk,
	input  wire            rstN,
	input  wire            subframeStb,
	input  wire [NERR-1:0] errIn,
	input  wire [NERR-1:0] errPass,
	output reg             rxErr_r,
	output reg  [NERR-1:0] errEvt_r
);

	always @(posedge clk) begin
		if (!rstN) begin
			rxErr_r  <= 1'b0;
			errEvt_r <= {NERR{1'b0}};
		end else begin
			errEvt_r <= {NERR{1'b0}};
			if (subframeStb) begin
				// sampled per sub-frame, so it rises and falls with the first one that differs
				rxErr_r  <= |(errIn & errPass);
				errEvt_r <= errIn;
			end
		end
	end

endmodule // rei_rxerr

// ===== src/rei_ratio.v
`timescale 1ns/10ps
`include "rei_regs.vh"

// ==========================================
// reference clock to input frame ratio meter
module rei_ratio #(
	parameter CW = 12
) (
	input  wire       clk,
	input  wire       rstN,
	input  wire       refClk,
	input  wire       frameStb,
	output reg  [7:0] ratio_r,
	output reg        upd_r
);

	reg  [CW-1:0] cnt_r;
	reg           refQ_r;
	wire          refRise = refClk & ~refQ_r;
	wire [CW-1:0] scaled  = cnt_r >> `REI_RATIO_SHIFT;

	always @(posedge clk) begin
		if (!rstN) begin
			cnt_r   <= {CW{1'b0}};
			refQ_r  <= 1'b0;
			ratio_r <= `REI_RST_RATIO;
			upd_r   <= 1'b0;
		end else begin
			refQ_r <= refClk;
			upd_r  <= frameStb;
			if (frameStb) begin
				// saturate instead of wrapping when the input rate is very low
				ratio_r <= (|scaled[CW-1:8]) ? `REI_RATIO_MAX : scaled[7:0];
				cnt_r   <= {{(CW-1){1'b0}}, refRise};
			end else if (refRise && !(&cnt_r)) begin
				cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // rei_ratio

// ===== src/rei_top.v
`timescale 1ns/10ps
`include "rei_regs.vh"

// Function
// - while reset is low the block shows low power and every register holds its reset value.
// - the master clock output follows the recovered 256x clock by default, or a 128x one when chosen.
// - the receiver error output is high on a receiver problem and is re-evaluated each sub-frame.
// - its sources are validity, parity, bi-phase, confidence, subcode crc, channel status crc and unlock.
// - each source has its own mask bit and a masked source cannot raise the receiver error output.
// - the receiver error output rises on any unmasked error and falls once none remains.
// - a condition reaches the interrupt only when its own mask bit unmasks it.
// - the causes of an interrupt are kept in status bits that software reads back.
// - the interrupt pin has selectable polarity and push-pull or open-drain drive.
// - an asserted interrupt stays until its status was read and all status bits are zero; only the pin holds, irq_r just follows the unmasked status bits.
// - in reference clock mode the system reference clock drives the master clock output.
// - the ratio register is measured against the system reference clock.
// - a static mode pin chooses software control over the bus or hardware control by pins; there are no such pins, hardware mode only blocks bus writes.

module rei_top #(
	parameter NERR = `REI_ERR_W,
	parameter CW   = 12
) (
	input  wire            clk,
	input  wire            rst_n,
	input  wire [7:0]      address,
	input  wire            read,
	input  wire            write,
	input  wire [31:0]     writedata,
	input  wire [3:0]      byteenable,
	output reg  [31:0]     readdata,
	output reg             waitrequest,
	input  wire            subframeStb,
	input  wire            frameStb,
	input  wire [NERR-1:0] errIn,
	input  wire            recoveredMasterClock,
	input  wire            systemReferenceClock,
	input  wire            hwModePin,
	output wire            receiverErrorOut,
	output reg             intPinOut_r,
	output reg             intPinOeN_r,
	output reg             irq_r,
	output reg             mclkOut_r,
	output reg             lowPower_r,
	output reg             hwMode_r
);

	// ==========================================
	// reset release
	reg rstN1_r;
	reg rstN2_r;
	wire rstN = rstN2_r & rst_n;

	always @(posedge clk) begin
		if (!rst_n) begin
			rstN1_r <= 1'b0;
			rstN2_r <= 1'b0;
		end else begin
			// all state on rstN leaves reset on the same edge of clk; lowPower_r falls on that same edge
			rstN1_r <= 1'b1;
			rstN2_r <= rstN1_r;
		end
	end

	always @(posedge clk) begin
		if (!rst_n)
			lowPower_r <= 1'b1;
		else
			lowPower_r <= ~rstN2_r;
	end

	// ==========================================
	// mode strap, caught once after release
	reg modeTaken_r;

	always @(posedge clk) begin
		if (!rstN) begin
			hwMode_r    <= 1'b0;
			modeTaken_r <= 1'b0;
		end else if (!modeTaken_r) begin
			// pin is static, a later change is ignored until next reset
			hwMode_r    <= hwModePin;
			modeTaken_r <= 1'b1;
		end
	end

	// ==========================================
	// registers
	reg  [`REI_CTRL_W-1:0] ctrl_r;
	reg  [NERR-1:0]        errPass_r;
	reg  [`REI_INT_W-1:0]  intStat_r;
	reg  [`REI_INT_W-1:0]  intStat_nxt;
	reg  [`REI_INT_W-1:0]  intMask_r;
	reg                    intAct_r;
	reg                    statRead_r;
	wire [7:0]             ratio;
	wire                   ratioUpd;
	wire [NERR-1:0]        errEvt;

	wire acc   = (read | write) & ~waitrequest;
	wire wrAcc = acc & write & byteenable[0] & ~hwMode_r;
	wire rdAcc = acc & read;

	function hit;
		input [7:0] a;
		input [7:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	// ==========================================
	// avalon slave: one wait state on every access
	always @(posedge clk) begin
		if (!rstN) begin
			waitrequest <= 1'b1;
			readdata    <= 32'h00000000;
		end else if ((read | write) && waitrequest) begin
			waitrequest <= 1'b0;
			// read data stands until the next accepted read, a write leaves it alone
			if (read) begin
				readdata <= 32'h00000000;
				case (1'b1)
				hit(address, `REI_OFS_CTRL):    readdata[`REI_CTRL_W-1:0] <= ctrl_r;
				hit(address, `REI_OFS_ERRMASK): readdata[NERR-1:0] <= errPass_r;
				hit(address, `REI_OFS_INTSTAT): readdata[`REI_INT_W-1:0] <= intStat_r;
				hit(address, `REI_OFS_INTMASK): readdata[`REI_INT_W-1:0] <= intMask_r;
				hit(address, `REI_OFS_RATIO):   readdata[7:0] <= ratio;
				hit(address, `REI_OFS_STATE): begin
					readdata[`REI_ST_RXERR]  <= receiverErrorOut;
					readdata[`REI_ST_INTACT] <= intAct_r;
					readdata[`REI_ST_HWMODE] <= hwMode_r;
					readdata[`REI_ST_RDSEEN] <= statRead_r;
				end
				default: readdata <= 32'h00000000;
				endcase
			end
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// in hardware mode the bus cannot change the configuration
	always @(posedge clk) begin
		if (!rstN) begin
			ctrl_r    <= `REI_RST_CTRL;
			errPass_r <= `REI_RST_ERRMASK;
			intMask_r <= `REI_RST_INTMASK;
		end else if (wrAcc) begin
			if (hit(address, `REI_OFS_CTRL))
				ctrl_r <= writedata[`REI_CTRL_W-1:0];
			if (hit(address, `REI_OFS_ERRMASK))
				errPass_r <= writedata[NERR-1:0];
			if (hit(address, `REI_OFS_INTMASK))
				intMask_r <= writedata[`REI_INT_W-1:0];
		end
	end

	// ==========================================
	// receiver error and ratio
	rei_rxerr #(
		.NERR (NERR)
	) uRxErr (
		.clk         (clk),
		.rstN        (rstN),
		.subframeStb (subframeStb),
		.errIn       (errIn),
		.errPass     (errPass_r),
		.rxErr_r     (receiverErrorOut),
		.errEvt_r    (errEvt)
	);

	rei_ratio #(
		.CW (CW)
	) uRatio (
		.clk      (clk),
		.rstN     (rstN),
		.refClk   (systemReferenceClock),
		.frameStb (frameStb),
		.ratio_r  (ratio),
		.upd_r    (ratioUpd)
	);

	// ==========================================
	// interrupt status, write one to clear, set wins
	wire [`REI_INT_W-1:0] evt = {ratioUpd, errEvt};
	wire [`REI_INT_W-1:0] clr = (wrAcc && hit(address, `REI_OFS_INTSTAT)) ?
	                            writedata[`REI_INT_W-1:0] : {`REI_INT_W{1'b0}};

	always @* begin
		intStat_nxt = (intStat_r & ~clr) | evt;
	end

	wire pend = |(intStat_nxt & intMask_r);

	always @(posedge clk) begin
		if (!rstN) begin
			intStat_r  <= {`REI_INT_W{1'b0}};
			intAct_r   <= 1'b0;
			statRead_r <= 1'b0;
			irq_r      <= 1'b0;
		end else begin
			intStat_r <= intStat_nxt;
			irq_r     <= pend;
			if (!intAct_r) begin
				intAct_r   <= pend;
				statRead_r <= 1'b0;
			end else begin
				// a read alone is not enough: every status bit must be back at zero
				if (statRead_r && (intStat_nxt == {`REI_INT_W{1'b0}}))
					intAct_r <= 1'b0;
				if (rdAcc && hit(address, `REI_OFS_INTSTAT))
					statRead_r <= 1'b1;
			end
		end
	end

	// ==========================================
	// interrupt pin driver
	wire intLevel = intAct_r ~^ ctrl_r[`REI_CTRL_POL];

	always @(posedge clk) begin
		if (!rstN) begin
			intPinOut_r <= 1'b0;
			intPinOeN_r <= 1'b1;
		end else if (ctrl_r[`REI_CTRL_OD]) begin
			// open drain only pulls low; the high level comes from the pull-up
			intPinOut_r <= 1'b0;
			intPinOeN_r <= intLevel;
		end else begin
			intPinOut_r <= intLevel;
			intPinOeN_r <= 1'b0;
		end
	end

	// ==========================================
	// master clock select
	reg recQ_r;
	reg half_r;

	always @(posedge clk) begin
		if (!rstN) begin
			recQ_r    <= 1'b0;
			half_r    <= 1'b0;
			mclkOut_r <= 1'b0;
		end else begin
			recQ_r <= recoveredMasterClock;
			if (recoveredMasterClock && !recQ_r)
				half_r <= ~half_r;
			// sampled copy: only as exact as clk is fast against the selected clock
			if (ctrl_r[`REI_CTRL_REFCLK])
				mclkOut_r <= systemReferenceClock;
			else if (ctrl_r[`REI_CTRL_HALF])
				mclkOut_r <= half_r;
			else
				mclkOut_r <= recoveredMasterClock;
		end
	end

endmodule // rei_top

// ===== dv/rei_top_chk.sv
`timescale 1ns/10ps
// ========================================
// port checker
module rei_top_chk #(
	parameter NERR = 7
) (
	input wire logic            clk,
	input wire logic            rst_n,
	input wire logic            read,
	input wire logic            write,
	input wire logic [31:0]     readdata,
	input wire logic            waitrequest,
	input wire logic            subframeStb,
	input wire logic [NERR-1:0] errIn,
	input wire logic            receiverErrorOut,
	input wire logic            intPinOut_r,
	input wire logic            intPinOeN_r,
	input wire logic            lowPower_r,
	input wire logic            hwMode_r
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_ack;
		!waitrequest ##1 waitrequest;
	endsequence
	sequence s_rstHigh2;
		$past(rst_n) && $past(rst_n, 2);
	endsequence
	a_wait_single: assert property (!waitrequest |-> s_ack)
		else $error("waitrequest low longer than one cycle");
	a_ack_cause: assert property (!waitrequest |-> $past(read || write))
		else $error("answer without request");
	a_rdata_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
		else $error("readdata changed without read");
	a_rxerr_hold: assert property (!subframeStb |=> $stable(receiverErrorOut))
		else $error("receiver error changed between sub-frames");
	a_rxerr_clear: assert property (subframeStb && errIn == '0 |=> !receiverErrorOut)
		else $error("receiver error high with no error");
	a_pin_release: assert property (intPinOeN_r |-> !intPinOut_r)
		else $error("released pin drives one");
	a_lp_release: assert property ($fell(lowPower_r) |-> s_rstHigh2)
		else $error("low power left too early");
	a_lp_quiet: assert property (lowPower_r |-> !receiverErrorOut)
		else $error("receiver error during reset");
	a_hw_static: assert property (!lowPower_r && $past(!lowPower_r) && $past(!lowPower_r, 2)
		|-> $stable(hwMode_r))
		else $error("mode changed while running");
endmodule // rei_top_chk

bind rei_top rei_top_chk #(.NERR(NERR)) rei_top_chk_inst (.clk, .rst_n, .read, .write, .readdata,
	.waitrequest, .subframeStb, .errIn, .receiverErrorOut, .intPinOut_r, .intPinOeN_r, .lowPower_r,
	.hwMode_r);

// ===== dv/rei_host_model.sv
`timescale 1ns/10ps
// ========================================
// host side of the interrupt wire, pulled up
module rei_host_model (
	input  wire logic intPinOut_r,
	input  wire logic intPinOeN_r,
	output wire logic intLevel
);
	assign intLevel = intPinOeN_r ? 1'b1 : intPinOut_r;
endmodule // rei_host_model

// ===== dv/rei_top_test.sv
`timescale 1ns/10ps
`include "rei_regs.vh"
// ========================================
// register level bench
module rei_top_test;
	localparam logic [7:0] ST = `REI_OFS_INTSTAT;
	localparam logic [7:0] CT = `REI_OFS_CTRL;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  address = 8'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata, q;
	logic        waitrequest, receiverErrorOut, intPinOut_r, intPinOeN_r, irq_r, mclkOut_r;
	logic        lowPower_r, hwMode_r, intLevel;
	logic        subframeStb = 1'b0, frameStb = 1'b0, hwModePin = 1'b0;
	logic        recClk = 1'b0, refClk = 1'b1;
	logic [6:0]  errIn = 7'h00;
	int          n_errors = 0, compares = 0, cyc = 0;
	logic [7:0]  ofs [5] = '{CT, `REI_OFS_ERRMASK, `REI_OFS_INTMASK, `REI_OFS_RATIO, 8'h20};
	logic [31:0] rv [5] = '{32'h4, 32'h7F, 32'h0, 32'h0, 32'h0};

	rei_top #(.NERR(7), .CW(12)) rei_top_inst (.clk, .rst_n, .address, .read, .write, .writedata,
		.byteenable(4'hF), .readdata, .waitrequest, .subframeStb, .frameStb, .errIn,
		.recoveredMasterClock(recClk), .systemReferenceClock(refClk), .hwModePin, .receiverErrorOut,
		.intPinOut_r, .intPinOeN_r, .irq_r, .mclkOut_r, .lowPower_r, .hwMode_r);
	rei_host_model rei_host_model_inst (.intPinOut_r, .intPinOeN_r, .intLevel);

	always #2.5 clk = ~clk;
	// both slow clocks toggle in antiphase so the selected source is visible
	always @(posedge clk) begin
		recClk <= ~recClk;
		refClk <= ~refClk;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= d;
		do @(posedge clk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic sf(input logic [6:0] e);
		@(posedge clk);
		errIn <= e;
		subframeStb <= 1'b1;
		@(posedge clk);
		subframeStb <= 1'b0;
		errIn <= 7'h00;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic fr();
		@(posedge clk);
		frameStb <= 1'b1;
		@(posedge clk);
		frameStb <= 1'b0;
	endtask
	task automatic stop_test();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b1, 8'h20, 32'hFF);
		foreach (ofs[i]) begin
			bus(1'b0, ofs[i], 32'h0);
			chk("reset value", q, rv[i]);
		end
		$display("end reset");
		for (int i = 0; i < 7; i++) begin
			sf(7'h01 << i);
			chk("rxerr set", receiverErrorOut, 1'b1);
			repeat (3) @(posedge clk);
			chk("rxerr hold", receiverErrorOut, 1'b1);
			sf(7'h00);
			chk("rxerr clear", receiverErrorOut, 1'b0);
			bus(1'b1, `REI_OFS_ERRMASK, 32'h7F ^ (32'h1 << i));
			sf(7'h01 << i);
			chk("rxerr masked", receiverErrorOut, 1'b0);
			bus(1'b1, `REI_OFS_ERRMASK, 32'h7F);
		end
		$display("end rxerr");
		bus(1'b1, ST, 32'hFF);
		bus(1'b1, `REI_OFS_INTMASK, 32'h2);
		sf(7'h01);
		chk("irq masked", irq_r, 1'b0);
		sf(7'h02);
		chk("irq", irq_r, 1'b1);
		chk("pin level", intPinOut_r, 1'b1);
		chk("pin driven", intPinOeN_r, 1'b0);
		bus(1'b0, ST, 32'h0);
		chk("cause", q, 32'h03);
		chk("pin held", intPinOut_r, 1'b1);
		bus(1'b1, ST, 32'h03);
		repeat (2) @(posedge clk);
		chk("pin off", intPinOut_r, 1'b0);
		// open drain, active low: cleared before any read, so it must hold
		bus(1'b1, CT, 32'h8);
		repeat (2) @(posedge clk);
		chk("od idle", intLevel, 1'b1);
		sf(7'h02);
		chk("od active", intLevel, 1'b0);
		bus(1'b1, ST, 32'h02);
		repeat (2) @(posedge clk);
		chk("irq clear", irq_r, 1'b0);
		chk("od held", intLevel, 1'b0);
		bus(1'b0, ST, 32'h0);
		repeat (3) @(posedge clk);
		chk("od off", intLevel, 1'b1);
		$display("end irq");
		repeat (3) @(negedge clk) chk("mclk rec", mclkOut_r, !recClk);
		bus(1'b1, CT, 32'hA);
		repeat (2) @(posedge clk);
		@(negedge clk) q[0] = mclkOut_r;
		repeat (3) begin
			repeat (2) @(negedge clk);
			chk("mclk half", mclkOut_r, !q[0]);
			q[0] = mclkOut_r;
		end
		bus(1'b1, CT, 32'h9);
		repeat (2) @(posedge clk);
		repeat (3) @(negedge clk) chk("mclk ref", mclkOut_r, !refClk);
		$display("end mclk");
		// 512 cycles per frame with a rise every 2 cycles gives 1.0
		bus(1'b1, ST, 32'hFF);
		fr();
		repeat (510) @(posedge clk);
		fr();
		repeat (4) @(posedge clk);
		bus(1'b0, `REI_OFS_RATIO, 32'h0);
		chk("ratio", q, 32'h40);
		bus(1'b0, ST, 32'h0);
		chk("ratio event", q, 32'h80);
		$display("end ratio");
		hwModePin <= 1'b1;
		rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk("low power", lowPower_r, 1'b1);
		rst_n <= 1'b1;
		bus(1'b1, CT, 32'h1);
		bus(1'b0, CT, 32'h0);
		chk("hw write", q, 32'h4);
		chk("hw mode", hwMode_r, 1'b1);
		bus(1'b0, `REI_OFS_STATE, 32'h0);
		chk("hw state", q[2], 1'b1);
		$display("end hwmode");
		stop_test();
	end
endmodule // rei_top_test
